// ---- testbench.sv ----
// Purpose: Self-checking bench for the waveform FIFO register block
// Assumes: hready looped back from hreadyout; pace inputs held low
// Notes: Byte address is the register index times four
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // Signals
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, wave_data, rd;
  logic [1:0] htrans, fifo_clock_select, t_addr;
  logic [2:0] hsize;
  logic counter0_clock_select, counter0_gate_enable, timer_out0, ext_pace;
  logic dio_oe_low, dio_oe_high, wave_strobe;
  logic [7:0] timer_rdata, t_wd;
  logic [15:0] dio_in, dio_out;
  wave_regs_pkg::tmr_bus_s timer_bus;
  logic [31:0] words[$];
  int failures, comparisons;

  assign hready = hreadyout;

  wave_regs uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .counter0_clock_select(counter0_clock_select),
    .counter0_gate_enable(counter0_gate_enable), .fifo_clock_select(fifo_clock_select),
    .timer_bus(timer_bus), .timer_rdata(timer_rdata), .timer_out0(timer_out0),
    .ext_pace(ext_pace), .dio_in(dio_in), .dio_out(dio_out), .dio_oe_low(dio_oe_low),
    .dio_oe_high(dio_oe_high), .wave_data(wave_data), .wave_strobe(wave_strobe)
  );

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // Capture timer strobes and popped words as they appear
  always @(posedge hclk) begin
    if (timer_bus.wr_n === 1'b0) begin
      t_addr = timer_bus.addr;
      t_wd = timer_bus.wdata;
    end
    if (wave_strobe === 1'b1) begin
      words.push_back(wave_data);
    end
  end

  // ==========================================================
  // Tasks
  task automatic print_verdict;
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Master waits on hready only; fails once a transfer takes 60 cycles
  task automatic bus(input logic wr_en, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr_en;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 60);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 60);
    rd = hrdata;
    if (n >= 60) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 8) begin
      @(posedge hclk);
      n++;
    end
    check({31'h0, irq}, {31'h0, e});
  endtask

  task automatic io_case(input logic [31:0] w, input logic [6:0] e);
    wr(32'ha8, w);
    rdc(32'ha8, {25'h0, e});
    check({26'h0, fifo_clock_select, dio_oe_high, dio_oe_low, counter0_gate_enable,
      counter0_clock_select}, {26'h0, e[6:5], ~e[4], ~e[3], e[1], e[0]});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    int n;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    timer_rdata = 8'h0;
    timer_out0 = 1'b0;
    ext_pace = 1'b0;
    dio_in = 16'h0;
    failures = 0;
    comparisons = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({dio_out, 7'h0, hresp, irq, wave_strobe, dio_oe_high, dio_oe_low, fifo_clock_select,
      counter0_gate_enable, counter0_clock_select}, 32'h00000030);
    rdc(32'hb8, 32'h6);
    io_case(32'hffffffff, 7'h7b);
    io_case(32'h00000031, 7'h31);
    io_case(32'h0000000a, 7'h0a);
    io_case(32'h0, 7'h0);
    dio_in <= 16'h3c5a;
    wr(32'hf8, 32'hffffa5c3);
    @(posedge hclk);
    check({16'h0, dio_out}, 32'h0000a5c3);
    rdc(32'hf8, 32'h00003c5a);
    for (int i = 0; i < 4; i++) begin
      timer_rdata <= 8'ha0 + 8'(i);
      wr(32'hc0 + 32'(8 * i), 32'h0000ab30 + 32'(i));
      check({30'h0, t_addr}, 32'(i));
      check({24'h0, t_wd}, 32'h30 + 32'(i));
      rdc(32'hc0 + 32'(8 * i), 32'ha0 + 32'(i));
    end
    wr(32'h1f0, 32'hffffffff);
    rdc(32'h1f0, 32'h0);
    // Pace source idle, so the FIFO only fills
    for (int i = 1; i <= 17; i++) begin
      wr(32'h100, 32'(i));
      wr(32'h108, 32'h0);
      if (i == 7) rdc(32'hb8, 32'h7);
      if (i == 8) rdc(32'hb8, 32'h5);
      if (i == 15) rdc(32'hb8, 32'h5);
      if (i == 16) rdc(32'hb8, 32'h1);
    end
    rdc(32'h140, 32'h6);
    wait_irq(1'b0);
    wr(32'h148, 32'h4);
    wait_irq(1'b1);
    wr(32'h140, 32'h4);
    wait_irq(1'b0);
    rdc(32'h140, 32'h2);
    wr(32'hb0, 32'h12345678);
    rdc(32'hb8, 32'h6);
    wr(32'h140, 32'h7);
    // Second high write reuses the latched low word
    wr(32'h100, 32'hffff1111);
    wr(32'h108, 32'h00002222);
    wr(32'h108, 32'h00003333);
    wr(32'ha8, 32'h40);
    n = 0;
    while (words.size() < 2 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    check(32'(words.size()), 32'h2);
    check(words[0], 32'h22221111);
    check(words[1], 32'h33331111);
    rdc(32'hb8, 32'h6);
    rdc(32'h140, 32'h1);
    print_verdict();
  end
endmodule // testbench

// ---- wave_regs.sv ----
// Purpose: Register bank for I/O setting, waveform FIFO, timer pass-through, digital I/O
// Assumes: Single AHB-Lite master, word transfers only, external timer chip on byte bus
// Notes: Every access inserts one wait state; timer accesses add the strobe time
//
// Contract
// - I/O setting bit 0 picks timer channel 0 clock: internal or connector.
// - I/O setting bit 1 gates timer channel 0 counting.
// - Bits 6:5 pick FIFO pace: timer, 5 MHz, 10 MHz, external.
// - Digital outputs drive zero after reset.
// - Any write to the clear location empties the FIFO.
// - Status bit 0 low while FIFO is empty.
// - Status bit 1 low once FIFO reaches half depth.
// - Status bit 2 low when FIFO full; upper bits zero.
// - Four locations pass bytes to timer chip; bits 15:8 read zero.
// - Digital data write drives 16 outputs; read returns 16 inputs.
// - Low then high buffer word written; device pushes the pattern.
// - Each FIFO entry is 32 bits from the two buffer words.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module wave_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  output logic counter0_clock_select,
  output logic counter0_gate_enable,
  output logic [1:0] fifo_clock_select,
  output wave_regs_pkg::tmr_bus_s timer_bus,
  input wire logic [7:0] timer_rdata,
  input wire logic timer_out0,
  input wire logic ext_pace,
  input wire logic [15:0] dio_in,
  output logic [15:0] dio_out,
  output logic dio_oe_low,
  output logic dio_oe_high,
  output logic [31:0] wave_data,
  output logic wave_strobe
);

  // ==========================================================
  // State
  typedef struct packed {
    wave_regs_pkg::bus_e bus;
    logic wr;
    logic [7:0] idx;
    logic [2:0] tcnt;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic [15:0] io;
    logic oe_lo;
    logic oe_hi;
    logic [15:0] dio_out;
    logic [15:0] buf_lo;
    logic [wave_regs_pkg::FIFO_DEPTH-1:0][31:0] mem;
    logic [3:0] wp;
    logic [3:0] rp;
    logic [4:0] cnt;
    logic [31:0] wave;
    logic wave_stb;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic irq;
    wave_regs_pkg::tmr_bus_s tmr;
    logic [2:0] div;
    logic [2:0] s_ext;
    logic [2:0] s_tout;
    logic f_ext;
    logic f_tout;
    logic [15:0] d1, d2, d3, dio_f;
    logic [7:0] r1, r2, r3, rd_f;
  } state_s;

  state_s q, n;

  // Accept a bit only once the second and third stages agree
  function automatic logic [15:0] agree(input logic [15:0] s2, input logic [15:0] s3,
                                        input logic [15:0] prev);
    agree = ((s2 ~^ s3) & s3) | (~(s2 ~^ s3) & prev);
  endfunction

  // Active-low flags: bit0 empty, bit1 half, bit2 full
  function automatic logic [2:0] flags(input logic [4:0] c);
    flags = {c != wave_regs_pkg::FIFO_FULL, c < wave_regs_pkg::FIFO_HALF, c != 5'h00};
  endfunction

  logic data_wr, clr, hi_wr, tick, push, pop, ovf, accept;
  logic [15:0] tmp16;
  logic [15:0] tmp_rd;

  // ==========================================================
  // Next state
  always_comb begin
    n = q;
    n.wave_stb = 1'b0;
    n.resp = 1'b0;
    accept = hsel && htrans[1] && hready && q.ready;
    data_wr = (q.bus == wave_regs_pkg::BUS_DATA) && q.wr;
    clr = data_wr && (q.idx == wave_regs_pkg::IDX_FIFO_CLEAR);
    hi_wr = data_wr && (q.idx == wave_regs_pkg::IDX_BUF_HIGH);

    // Pin synchronisers
    n.s_ext = {q.s_ext[1:0], ext_pace};
    n.s_tout = {q.s_tout[1:0], timer_out0};
    tmp16 = agree({15'h0, q.s_ext[1]}, {15'h0, q.s_ext[2]}, {15'h0, q.f_ext});
    n.f_ext = tmp16[0];
    tmp16 = agree({15'h0, q.s_tout[1]}, {15'h0, q.s_tout[2]}, {15'h0, q.f_tout});
    n.f_tout = tmp16[0];
    n.d1 = dio_in;
    n.d2 = q.d1;
    n.d3 = q.d2;
    n.dio_f = agree(q.d2, q.d3, q.dio_f);
    n.r1 = timer_rdata;
    n.r2 = q.r1;
    n.r3 = q.r2;
    tmp_rd = agree({8'h0, q.r2}, {8'h0, q.r3}, {8'h0, q.rd_f});
    n.rd_f = tmp_rd[7:0];

    // Pace tick
    n.div = q.div + 3'h1;
    unique case (wave_regs_pkg::pace_e'(q.io[wave_regs_pkg::IO_PACE_LSB +: 2]))
      wave_regs_pkg::PACE_TIMER: tick = n.f_tout && !q.f_tout;
      wave_regs_pkg::PACE_5M: tick = (q.div == wave_regs_pkg::DIV5_LAST);
      wave_regs_pkg::PACE_10M: tick = (q.div[1:0] == wave_regs_pkg::DIV10_LAST);
      wave_regs_pkg::PACE_EXT: tick = n.f_ext && !q.f_ext;
    endcase

    // FIFO; a clear overrides a push or pop in the same cycle
    pop = tick && (q.cnt != 5'h00) && !clr;
    push = hi_wr && ((q.cnt != wave_regs_pkg::FIFO_FULL) || pop) && !clr;
    ovf = hi_wr && !push && !clr;
    if (pop) begin
      n.wave = q.mem[q.rp];
      n.wave_stb = 1'b1;
      n.rp = q.rp + 4'h1;
    end
    if (push) begin
      n.mem[q.wp] = {hwdata[15:0], q.buf_lo};
      n.wp = q.wp + 4'h1;
    end
    n.cnt = q.cnt + 5'(push) - 5'(pop);
    if (clr) begin
      n.wp = 4'h0;
      n.rp = 4'h0;
      n.cnt = 5'h00;
    end

    // Bus
    unique case (q.bus)
      wave_regs_pkg::BUS_IDLE: begin
        if (accept) begin
          n.bus = wave_regs_pkg::BUS_DATA;
          n.ready = 1'b0;
          n.wr = hwrite;
          n.idx = haddr[9:2];
        end
      end
      wave_regs_pkg::BUS_DATA: begin
        n.rdata = 32'h0;
        if (q.idx[7:3] == wave_regs_pkg::IDX_TMR_CNT0[7:3] && !q.idx[0]) begin
          n.tmr.addr = q.idx[2:1];
          n.tmr.wdata = hwdata[7:0];
          n.tmr.wr_n = !q.wr;
          n.tmr.rd_n = q.wr;
          n.tcnt = wave_regs_pkg::TMR_LAST;
          n.bus = wave_regs_pkg::BUS_TMR;
        end else begin
          n.ready = 1'b1;
          n.bus = wave_regs_pkg::BUS_IDLE;
          if (q.wr) begin
            unique case (q.idx)
              wave_regs_pkg::IDX_IO_SETTING: begin
                n.io = hwdata[15:0] & wave_regs_pkg::IO_MASK;
                n.oe_lo = !hwdata[wave_regs_pkg::IO_LOW_DIR];
                n.oe_hi = !hwdata[wave_regs_pkg::IO_HIGH_DIR];
              end
              wave_regs_pkg::IDX_DIO_DATA: n.dio_out = hwdata[15:0];
              wave_regs_pkg::IDX_BUF_LOW: n.buf_lo = hwdata[15:0];
              wave_regs_pkg::IDX_IRQ_MASK: n.irq_mask = hwdata[2:0];
              default: ;
            endcase
          end else begin
            unique case (q.idx)
              wave_regs_pkg::IDX_IO_SETTING: n.rdata = {16'h0, q.io};
              wave_regs_pkg::IDX_FIFO_STATUS: n.rdata = {29'h0, flags(q.cnt)};
              wave_regs_pkg::IDX_DIO_DATA: n.rdata = {16'h0, q.dio_f};
              wave_regs_pkg::IDX_IRQ_STATUS: n.rdata = {29'h0, q.irq_st};
              wave_regs_pkg::IDX_IRQ_MASK: n.rdata = {29'h0, q.irq_mask};
              default: n.rdata = 32'h0;
            endcase
          end
        end
      end
      wave_regs_pkg::BUS_TMR: begin
        if (q.tcnt == 3'h0) begin
          // Strobe held long enough for the pin filter to settle
          n.tmr.wr_n = 1'b1;
          n.tmr.rd_n = 1'b1;
          n.rdata = {24'h0, q.rd_f};
          n.ready = 1'b1;
          n.bus = wave_regs_pkg::BUS_IDLE;
        end else begin
          n.tcnt = q.tcnt - 3'h1;
        end
      end
      default: begin
        n.bus = wave_regs_pkg::BUS_IDLE;
        n.ready = 1'b1;
      end
    endcase

    // Interrupts: a new event beats a write-one clear
    n.irq_st = q.irq_st;
    if (data_wr && q.idx == wave_regs_pkg::IDX_IRQ_STATUS) begin
      n.irq_st = q.irq_st & ~hwdata[2:0];
    end
    n.irq_st[wave_regs_pkg::EV_EMPTY] |= pop && !push && (q.cnt == 5'h01);
    n.irq_st[wave_regs_pkg::EV_HALF] |= (n.cnt == wave_regs_pkg::FIFO_HALF) &&
                                        (q.cnt < wave_regs_pkg::FIFO_HALF);
    n.irq_st[wave_regs_pkg::EV_OVERFLOW] |= ovf;
    n.irq = |(n.irq_st & n.irq_mask);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.bus <= wave_regs_pkg::BUS_IDLE;
      q.ready <= 1'b1;
      q.oe_lo <= 1'b1;
      q.oe_hi <= 1'b1;
      q.tmr.wr_n <= 1'b1;
      q.tmr.rd_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign hrdata = q.rdata;
  assign hreadyout = q.ready;
  assign hresp = q.resp;
  assign irq = q.irq;
  assign counter0_clock_select = q.io[wave_regs_pkg::IO_CLK_SEL];
  assign counter0_gate_enable = q.io[wave_regs_pkg::IO_GATE];
  assign fifo_clock_select = q.io[wave_regs_pkg::IO_PACE_LSB +: 2];
  assign timer_bus = q.tmr;
  assign dio_out = q.dio_out;
  assign dio_oe_low = q.oe_lo;
  assign dio_oe_high = q.oe_hi;
  assign wave_data = q.wave;
  assign wave_strobe = q.wave_stb;

  // ==========================================================
  // Checks
  logic io_wr;
  assign io_wr = data_wr && (q.idx == wave_regs_pkg::IDX_IO_SETTING);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_clock_select: assert property (
    io_wr |=> counter0_clock_select == $past(hwdata[0]))
    else $error("clock select does not follow write");

  chk_gate_follow: assert property (
    io_wr |=> counter0_gate_enable == $past(hwdata[1]))
    else $error("gate does not follow write");

  chk_low_dir: assert property (
    io_wr |=> dio_oe_low != $past(hwdata[3]))
    else $error("low byte direction wrong");

  chk_high_dir: assert property (
    io_wr |=> dio_oe_high != $past(hwdata[4]))
    else $error("high byte direction wrong");

  chk_pace_spacing: assert property (
    (wave_strobe && fifo_clock_select == 2'b10 && !io_wr) |=> !wave_strobe [*3])
    else $error("10 MHz pace strobes too close");

  chk_clear_empties: assert property (
    clr |=> (q.cnt == 5'h00) && (q.wp == q.rp))
    else $error("clear did not empty FIFO");

  chk_clear_flags: assert property (
    clr |=> flags(q.cnt) == 3'b110)
    else $error("flags wrong after clear");

  chk_full_blocks: assert property (
    (hi_wr && !clr && !pop && q.cnt == wave_regs_pkg::FIFO_FULL)
      |=> q.cnt == wave_regs_pkg::FIFO_FULL && q.irq_st[wave_regs_pkg::EV_OVERFLOW])
    else $error("push into full FIFO not refused");

  chk_pack_word: assert property (
    push |=> q.mem[$past(q.wp)] == {$past(hwdata[15:0]), $past(q.buf_lo)})
    else $error("FIFO entry not packed from buffer words");

  chk_timer_strobe: assert property (
    $fell(timer_bus.rd_n) |-> !timer_bus.rd_n [*8] ##1 timer_bus.rd_n && hreadyout)
    else $error("timer read strobe length wrong");

endmodule // wave_regs

// ---- wave_regs_pkg.sv ----
// Purpose: Shared constants and types for the waveform FIFO register block
// Assumes: AHB-Lite slave, 32-bit data, one register per aligned word
// Notes: Register offsets are word indices; byte address is index times four
package wave_regs_pkg;

  // ==========================================================
  // Register indices (byte address = index * 4)
  localparam logic [7:0] IDX_IO_SETTING = 8'h2a;
  localparam logic [7:0] IDX_FIFO_CLEAR = 8'h2c;
  localparam logic [7:0] IDX_FIFO_STATUS = 8'h2e;
  localparam logic [7:0] IDX_TMR_CNT0 = 8'h30;
  localparam logic [7:0] IDX_TMR_CNT1 = 8'h32;
  localparam logic [7:0] IDX_TMR_CNT2 = 8'h34;
  localparam logic [7:0] IDX_TMR_CTRL = 8'h36;
  localparam logic [7:0] IDX_DIO_DATA = 8'h3e;
  localparam logic [7:0] IDX_BUF_LOW = 8'h40;
  localparam logic [7:0] IDX_BUF_HIGH = 8'h42;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h50;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h52;

  // ==========================================================
  // Field positions
  localparam int IO_CLK_SEL = 0;
  localparam int IO_GATE = 1;
  localparam int IO_LOW_DIR = 3;
  localparam int IO_HIGH_DIR = 4;
  localparam int IO_PACE_LSB = 5;
  localparam logic [15:0] IO_MASK = 16'h007b;
  localparam int EV_EMPTY = 0;
  localparam int EV_HALF = 1;
  localparam int EV_OVERFLOW = 2;

  // ==========================================================
  // FIFO geometry
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] FIFO_FULL = 5'h10;
  localparam logic [4:0] FIFO_HALF = 5'h08;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_NS = 25;
  localparam int PACE5_HZ = 5_000_000;
  localparam int PACE10_HZ = 10_000_000;
  localparam int DIV5 = CLK_HZ / PACE5_HZ;
  localparam int DIV10 = CLK_HZ / PACE10_HZ;
  localparam logic [2:0] DIV5_LAST = 3'(DIV5 - 1);
  localparam logic [1:0] DIV10_LAST = 2'(DIV10 - 1);
  localparam int TMR_STROBE_NS = 200;
  localparam int TMR_STROBE_CYC = (TMR_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] TMR_LAST = 3'(TMR_STROBE_CYC - 1);

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PACE_TIMER = 2'b00,
    PACE_5M = 2'b01,
    PACE_10M = 2'b10,
    PACE_EXT = 2'b11
  } pace_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_DATA = 2'b01,
    BUS_TMR = 2'b11
  } bus_e;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr_n;
    logic rd_n;
  } tmr_bus_s;

endpackage
